// file: bench/mtr_host_model.sv
// Host side of the register port: one access at a time, strobes change
// only at falling edges so the device samples settled values
module mtr_host_model #(
    parameter int QUIET_CYC = 10            // Pause after a restart, in clocks
) (
    input  wire logic       sys_clk,        // Device clock
    input  wire logic [7:0] reg_rdata,      // Read data from the device
    input  wire logic       reg_rvalid,     // Read data valid
    output logic            reg_wr,         // Write strobe
    output logic            reg_rd,         // Read strobe
    output logic      [7:0] reg_addr,       // Register offset
    output logic      [7:0] reg_wdata       // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    import mtr_pkg::*;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write; released lines show the inverse so stale data is never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // Stay off the bus while the device restarts
        if (a == OFS_RESTART && d == RESTART_KEY) begin
            repeat (QUIET_CYC) @(negedge sys_clk);
        end
    endtask

    // One read; a missing answer comes back unknown so it never matches
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask
endmodule // mtr_host_model

// file: bench/mtr_regs_tb_top.sv
// Self-checking bench for the motion and stillness register block
module mtr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mtr_pkg::*;

    // Short quiet time keeps the restart scenario brief
    localparam logic [WAIT_W-1:0] RSTC = 17'h8;

    logic        sys_clk = 1'b0;          // 4 ns clock
    logic        rst = 1'b1;              // Held for four cycles
    logic        sample_valid = 1'b0;     // Sample strobe
    logic [11:0] ax = 12'h000;            // Axis and temperature inputs
    logic [11:0] ay = 12'h000;
    logic [11:0] az = 12'h000;
    logic [11:0] tmp = 12'h000;
    logic        wake_mode = 1'b0;        // Wake-up mode level
    logic        ce = 1'b1;               // Clock enable, dropped in one test
    logic        reg_wr, reg_rd, reg_rvalid, motion_flag, stillness_flag;
    logic        int_out, int_oe_n, standby, restart_busy;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        busy_seen = 1'b0;        // Quiet time was observed
    int          errors = 0;
    int          checks_done = 0;

    always #2 sys_clk = ~sys_clk;

    // Remember that the quiet time showed up at all
    always @(negedge sys_clk) begin
        if (restart_busy === 1'b1) begin
            busy_seen = 1'b1;
        end
    end

    mtr_regs #(.RESTART_CYCLES(RSTC)) uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .axis_x(ax), .axis_y(ay),
        .axis_z(az), .temp_sample(tmp), .wake_mode(wake_mode), .motion_flag(motion_flag),
        .stillness_flag(stillness_flag), .int_out(int_out), .int_oe_n(int_oe_n),
        .standby(standby), .restart_busy(restart_busy));

    mtr_host_model #(.QUIET_CYC(10)) host (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read a register and compare it
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    // One sample pulse; flags are settled at the falling edge that ends it
    task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(negedge sys_clk);
        sample_valid = 1'b1;
        ax = x;
        ay = y;
        az = z;
        @(negedge sys_clk);
        sample_valid = 1'b0;
    endtask

    task automatic t_reset;
        for (int a = 8'h20; a <= 8'h27; a++) rchk(8'(a), 8'h00);
        rchk(OFS_RESTART, 8'h00);
        chk(8'({standby, int_oe_n}), 8'h03);
        $display("test reset done");
    endtask

    task automatic t_regs;
        host.wr(OFS_MLIM_HIGH, 8'hFF);
        rchk(OFS_MLIM_HIGH, 8'h07);
        host.wr(OFS_SLIM_HIGH, 8'hFF);
        rchk(OFS_SLIM_HIGH, 8'h07);
        host.wr(OFS_RESTART, 8'h33);
        rchk(OFS_RESTART, 8'h00);
        tmp = 12'h9A5;
        smp(12'h000, 12'h000, 12'h000);
        rchk(OFS_TEMP_LOW, 8'hA5);
        rchk(OFS_TEMP_HIGH, 8'hF9);
        tmp = 12'h3C2;
        smp(12'h000, 12'h000, 12'h000);
        rchk(OFS_TEMP_HIGH, 8'h03);
        $display("test registers done");
    endtask

    // Limit 261, hold 3; a sample at the limit breaks the run
    task automatic t_motion;
        host.wr(OFS_MLIM_LOW, 8'h05);
        host.wr(OFS_MLIM_HIGH, 8'h01);
        host.wr(OFS_MHOLD, 8'h03);
        host.wr(OFS_DETECT_CTL, 8'h01);
        smp(12'h106, 12'h000, 12'h000);
        smp(12'h000, 12'hEFA, 12'h000);
        smp(12'h000, 12'h000, 12'h105);
        smp(12'h106, 12'h000, 12'h000);
        smp(12'h106, 12'h000, 12'h000);
        chk(8'(motion_flag), 8'h00);
        smp(12'h000, 12'h000, 12'hEFA);
        chk(8'(motion_flag), 8'h01);
        rchk(OFS_STATUS, 8'h10);
        host.wr(OFS_MHOLD, 8'h00);
        smp(12'h000, 12'h000, 12'h800);
        chk(8'(motion_flag), 8'h01);
        rchk(OFS_STATUS, 8'h10);
        host.wr(OFS_MHOLD, 8'h03);
        wake_mode = 1'b1;
        smp(12'h7FF, 12'h000, 12'h000);
        chk(8'(motion_flag), 8'h01);
        wake_mode = 1'b0;
        host.wr(OFS_DETECT_CTL, 8'h00);
        rchk(OFS_STATUS, 8'h10);
        repeat (3) smp(12'h7FF, 12'h000, 12'h000);
        chk(8'(motion_flag), 8'h00);
        $display("test motion done");
    endtask

    // Limit 16, hold built from both bytes
    task automatic t_still;
        host.wr(OFS_SLIM_LOW, 8'h10);
        host.wr(OFS_SLIM_HIGH, 8'h00);
        host.wr(OFS_SHOLD_LOW, 8'h02);
        host.wr(OFS_SHOLD_HIGH, 8'h00);
        host.wr(OFS_DETECT_CTL, 8'h04);
        smp(12'h00F, 12'hFF1, 12'h000);
        smp(12'h000, 12'h010, 12'h000);
        smp(12'h001, 12'h001, 12'h001);
        chk(8'(stillness_flag), 8'h00);
        smp(12'h001, 12'h001, 12'h001);
        chk(8'(stillness_flag), 8'h01);
        rchk(OFS_STATUS, 8'h20);
        host.wr(OFS_SHOLD_LOW, 8'h00);
        host.wr(OFS_SHOLD_HIGH, 8'h01);
        // The counter still holds the old run; a failing sample starts it afresh
        smp(12'h010, 12'h000, 12'h000);
        repeat (255) smp(12'h000, 12'h000, 12'h000);
        chk(8'(stillness_flag), 8'h00);
        smp(12'h000, 12'h000, 12'h000);
        chk(8'(stillness_flag), 8'h01);
        host.wr(OFS_SHOLD_HIGH, 8'h00);
        rchk(OFS_STATUS, 8'h20);
        smp(12'h000, 12'h000, 12'h000);
        chk(8'(stillness_flag), 8'h01);
        host.wr(OFS_DETECT_CTL, 8'h00);
        rchk(OFS_STATUS, 8'h20);
        repeat (3) smp(12'h000, 12'h000, 12'h000);
        chk(8'(stillness_flag), 8'h00);
        $display("test stillness done");
    endtask

    task automatic t_restart;
        host.wr(OFS_MLIM_LOW, 8'h55);
        host.wr(OFS_DETECT_CTL, 8'h05);
        host.wr(OFS_RESTART, RESTART_KEY);
        chk(8'({busy_seen, restart_busy}), 8'h02);
        chk(8'({int_out, int_oe_n, standby}), 8'h03);
        rchk(OFS_MLIM_LOW, 8'h00);
        rchk(OFS_DETECT_CTL, 8'h00);
        $display("test restart done");
    endtask

    // Clock enable low freezes everything, register writes included
    task automatic t_freeze;
        ce = 1'b0;
        host.wr(OFS_MLIM_LOW, 8'hAA);
        ce = 1'b1;
        rchk(OFS_MLIM_LOW, 8'h00);
        $display("test freeze done");
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Tests take about 660 clocks; allow roughly seven times that
    initial begin
        #20000;
        errors++;
        finish_test;
    end

    initial begin
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        t_reset;
        t_regs;
        t_motion;
        t_still;
        t_restart;
        t_freeze;
        finish_test;
    end
endmodule // mtr_regs_tb_top

// file: design/mtr_regs.sv
module mtr_regs #(
    parameter logic [mtr_pkg::WAIT_W-1:0] RESTART_CYCLES =
        mtr_pkg::RESTART_CYCLES[mtr_pkg::WAIT_W-1:0]   // Quiet time in clocks
) (
    input  wire logic                          sys_clk,       // 250 MHz clock
    input  wire logic                          rst,           // Synchronous reset
    input  wire logic                          ce,            // Clock enable
    input  wire logic                          reg_wr,        // Register write strobe
    input  wire logic                          reg_rd,        // Register read strobe
    input  wire logic [7:0]                    reg_addr,      // Register byte offset
    input  wire logic [7:0]                    reg_wdata,     // Write data
    output logic      [7:0]                    reg_rdata,     // Read data
    output logic                               reg_rvalid,    // Read data valid
    input  wire logic                          sample_valid,  // One pulse per output sample
    input  wire logic [mtr_pkg::SAMPLE_W-1:0]  axis_x,        // Signed axis samples
    input  wire logic [mtr_pkg::SAMPLE_W-1:0]  axis_y,
    input  wire logic [mtr_pkg::SAMPLE_W-1:0]  axis_z,
    input  wire logic [mtr_pkg::SAMPLE_W-1:0]  temp_sample,   // Signed temperature
    input  wire logic                          wake_mode,     // Wake-up mode active
    output logic                               motion_flag,   // Status bit 4
    output logic                               stillness_flag,// Status bit 5
    output logic                               int_out,       // Interrupt pin level
    output logic                               int_oe_n,      // Pin enable, low drives
    output logic                               standby,       // Sensor in standby
    output logic                               restart_busy   // Quiet time running
);
    import mtr_pkg::*;

    mtr_state_s cur_ff;   // Registered state
    mtr_state_s nxt_st;   // Next state

    // Magnitudes of the three axes; -2048 negates to 12'h800, read unsigned as 2048
    logic [SAMPLE_W-1:0] mag [3];
    logic [2:0]          above;   // Axis above motion limit
    logic [2:0]          below;   // Axis below stillness limit
    logic [10:0]         motion_limit;
    logic [10:0]         still_limit;
    logic [SAMPLE_W-1:0] axis_in [3];

    assign axis_in[0] = axis_x;
    assign axis_in[1] = axis_y;
    assign axis_in[2] = axis_z;
    assign motion_limit = {cur_ff.mlim_high, cur_ff.mlim_low};
    assign still_limit  = {cur_ff.slim_high, cur_ff.slim_low};

    // Per-axis magnitude and compare
    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign mag[i]   = axis_in[i][SAMPLE_W-1] ? SAMPLE_W'(-axis_in[i]) : axis_in[i];
        assign above[i] = mag[i] > {1'b0, motion_limit};
        assign below[i] = mag[i] < {1'b0, still_limit};
    end

    logic        act_on;        // Motion detection enabled
    logic        still_on;      // Stillness detection enabled
    logic        act_qual;      // Sample qualifies for motion
    logic        still_qual;    // Sample qualifies for stillness
    logic [7:0]  act_target;    // Effective motion hold count
    logic [15:0] still_target;  // Effective stillness hold count
    logic        bus_ok;        // Bus accepted outside quiet time
    logic        restart_hit;   // Key byte written to restart register
    logic        status_rd;     // Status read acknowledges flags
    logic        act_event;
    logic        still_event;
    logic [7:0]  act_next_cnt;
    logic [15:0] still_next_cnt;

    assign act_on      = cur_ff.detect_ctl[BIT_MOTION_ON];
    assign still_on    = cur_ff.detect_ctl[BIT_STILL_ON];
    assign act_qual    = |above;
    assign still_qual  = &below;
    // Zero behaves as one; wake-up mode needs only one sample
    assign act_target  = (wake_mode || cur_ff.mhold == 8'h00) ? 8'h01
                                                              : cur_ff.mhold;
    assign still_target = (cur_ff.shold == 16'h0000) ? 16'h0001 : cur_ff.shold;
    assign bus_ok      = cur_ff.mode == MTR_RUN;
    assign restart_hit = bus_ok && reg_wr && reg_addr == OFS_RESTART
                         && reg_wdata == RESTART_KEY;
    assign status_rd   = bus_ok && reg_rd && reg_addr == OFS_STATUS;
    // Counters saturate at their target so long runs never wrap
    assign act_next_cnt   = (cur_ff.mcnt >= act_target) ? act_target
                                                        : 8'(cur_ff.mcnt + 8'h01);
    assign still_next_cnt = (cur_ff.scnt >= still_target) ? still_target
                                                          : 16'(cur_ff.scnt + 16'h0001);
    assign act_event   = sample_valid && act_on && act_qual && act_next_cnt >= act_target;
    assign still_event = sample_valid && still_on && still_qual
                         && still_next_cnt >= still_target;

    // Next-state logic
    always_comb begin
        nxt_st        = cur_ff;
        nxt_st.rvalid = 1'b0;
        // Temperature tracks the newest sample
        if (sample_valid) begin
            nxt_st.temp = temp_sample;
        end
        // Hold counters step once per sample, restart on a miss
        if (!act_on) begin
            nxt_st.mcnt = 8'h00;
        end else if (sample_valid) begin
            nxt_st.mcnt = act_qual ? act_next_cnt : 8'h00;
        end
        if (!still_on) begin
            nxt_st.scnt = 16'h0000;
        end else if (sample_valid) begin
            nxt_st.scnt = still_qual ? still_next_cnt : 16'h0000;
        end
        // Status read clears flags; a same-cycle event wins
        if (status_rd) begin
            nxt_st.motion_flag = 1'b0;
            nxt_st.still_flag  = 1'b0;
        end
        if (act_event) begin
            nxt_st.motion_flag = 1'b1;
        end
        if (still_event) begin
            nxt_st.still_flag = 1'b1;
        end
        // Register reads
        if (bus_ok && reg_rd) begin
            nxt_st.rvalid = 1'b1;
            case (reg_addr)
                OFS_STATUS:     nxt_st.rdata = {2'b00, cur_ff.still_flag,
                                                cur_ff.motion_flag, 4'h0};
                OFS_TEMP_LOW:   nxt_st.rdata = cur_ff.temp[7:0];
                OFS_TEMP_HIGH:  nxt_st.rdata = {{4{cur_ff.temp[11]}},
                                                cur_ff.temp[11:8]};
                OFS_MLIM_LOW:   nxt_st.rdata = cur_ff.mlim_low;
                OFS_MLIM_HIGH:  nxt_st.rdata = {5'h00, cur_ff.mlim_high};
                OFS_MHOLD:      nxt_st.rdata = cur_ff.mhold;
                OFS_SLIM_LOW:   nxt_st.rdata = cur_ff.slim_low;
                OFS_SLIM_HIGH:  nxt_st.rdata = {5'h00, cur_ff.slim_high};
                OFS_SHOLD_LOW:  nxt_st.rdata = cur_ff.shold[7:0];
                OFS_SHOLD_HIGH: nxt_st.rdata = cur_ff.shold[15:8];
                OFS_DETECT_CTL: nxt_st.rdata = cur_ff.detect_ctl;
                // Restart register and unmapped offsets read zero
                default:        nxt_st.rdata = RST_BYTE;
            endcase
        end
        // Register writes
        if (bus_ok && reg_wr) begin
            case (reg_addr)
                OFS_MLIM_LOW:   nxt_st.mlim_low   = reg_wdata;
                OFS_MLIM_HIGH:  nxt_st.mlim_high  = reg_wdata[LIM_HIGH_W-1:0];
                OFS_MHOLD:      nxt_st.mhold      = reg_wdata;
                OFS_SLIM_LOW:   nxt_st.slim_low   = reg_wdata;
                OFS_SLIM_HIGH:  nxt_st.slim_high  = reg_wdata[LIM_HIGH_W-1:0];
                OFS_SHOLD_LOW:  nxt_st.shold[7:0] = reg_wdata;
                OFS_SHOLD_HIGH: nxt_st.shold[15:8] = reg_wdata;
                OFS_DETECT_CTL: nxt_st.detect_ctl = reg_wdata;
                default:        ;
            endcase
        end
        // Restart sequencing
        case (cur_ff.mode)
            MTR_RUN: begin
                if (restart_hit) begin
                    // Everything settable goes back to reset, pins released
                    nxt_st             = '0;
                    nxt_st.mode        = MTR_RESTART_WAIT;
                    nxt_st.wait_cnt    = RESTART_CYCLES;
                    nxt_st.temp        = cur_ff.temp;
                    nxt_st.int_oe_n    = 1'b1;
                    nxt_st.standby     = 1'b1;
                end
            end
            MTR_RESTART_WAIT: begin
                // Bus is ignored until the quiet time is over
                nxt_st.wait_cnt = WAIT_W'(cur_ff.wait_cnt - 1'b1);
                if (cur_ff.wait_cnt <= 1) begin
                    nxt_st.mode = MTR_RUN;
                end
            end
            default: nxt_st.mode = MTR_RUN;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ff          <= '0;
            cur_ff.int_oe_n <= 1'b1;
            cur_ff.standby  <= 1'b1;
        end else if (ce) begin
            cur_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register, except int_out, which is tied to zero
    assign reg_rdata      = cur_ff.rdata;
    assign reg_rvalid     = cur_ff.rvalid;
    assign motion_flag    = cur_ff.motion_flag;
    assign stillness_flag = cur_ff.still_flag;
    // No interrupt mapping here: the keeper holds the pin low
    assign int_out        = 1'b0;
    assign int_oe_n       = cur_ff.int_oe_n;
    assign standby        = cur_ff.standby;
    assign restart_busy   = cur_ff.mode == MTR_RESTART_WAIT;

    // All checks share the one clock; reset masks them
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Restart: the key write, then both limits back at zero, standby set and the quiet time running
    sequence s_restart_write;
        ce && restart_hit;
    endsequence
    sequence s_settings_cleared;
        motion_limit == 11'h000 && still_limit == 11'h000 && standby && restart_busy;
    endsequence

    // High temperature byte copies bit 11 into its top nibble
    a_temp_sign_copy: assert property (
        ce && bus_ok && reg_rd && reg_addr == OFS_TEMP_HIGH |=>
            reg_rvalid && reg_rdata[7:4] == {4{reg_rdata[3]}})
        else $error("temperature high byte not sign copied");
    // Restart clears the settings and enters the quiet time
    a_restart_clears: assert property (s_restart_write |=> s_settings_cleared)
        else $error("restart did not clear settings");
    // Interrupt pins let go so the keepers hold their level
    a_pins_released: assert property (s_restart_write |=> int_oe_n)
        else $error("interrupt pins still driven after restart");
    // Restart register is write-only
    a_restart_reads: assert property (
        ce && bus_ok && reg_rd && reg_addr == OFS_RESTART |=> reg_rdata == 8'h00)
        else $error("restart register read nonzero");
    // Three high bits land on top of the motion limit
    a_limit_join: assert property (
        ce && bus_ok && reg_wr && reg_addr == OFS_MLIM_HIGH |=>
            motion_limit[10:8] == $past(reg_wdata[2:0]))
        else $error("motion limit high bits misplaced");
    // Eight low bits form the bottom of the motion limit
    a_limit_low: assert property (
        ce && bus_ok && reg_wr && reg_addr == OFS_MLIM_LOW |=>
            motion_limit[7:0] == $past(reg_wdata))
        else $error("motion limit low bits misplaced");
    // Hold of zero or one: a single loud sample is enough
    a_motion_single: assert property (
        ce && sample_valid && act_on && act_qual && cur_ff.mhold <= 8'h01
            && !restart_hit |=> motion_flag)
        else $error("single sample did not raise motion");
    // Wake-up mode skips the hold count altogether
    a_wake_single: assert property (
        ce && sample_valid && act_on && act_qual && wake_mode && !restart_hit |=>
            motion_flag)
        else $error("wake-up mode did not take one sample");
    // A sample with any axis at or above the limit throws the stillness run away
    a_still_restart: assert property (
        ce && sample_valid && still_on && !still_qual && !restart_hit |=>
            cur_ff.scnt == 16'h0000)
        else $error("stillness counter not restarted");
    // A sample with no axis above the limit throws the motion run away
    a_motion_restart: assert property (
        ce && sample_valid && act_on && !act_qual && !restart_hit |=>
            cur_ff.mcnt == 8'h00)
        else $error("motion counter not restarted");
    // Disabled motion detection never raises its flag
    a_motion_off: assert property (
        ce && !act_on && !motion_flag && !restart_hit |=> !motion_flag)
        else $error("motion flagged while disabled");
    // Disabled stillness detection never raises its flag
    a_still_off: assert property (
        ce && !still_on && !stillness_flag && !restart_hit |=> !stillness_flag)
        else $error("stillness flagged while disabled");
    // Three high bits land on top of the stillness limit
    a_still_join: assert property (
        ce && bus_ok && reg_wr && reg_addr == OFS_SLIM_HIGH |=>
            still_limit[10:8] == $past(reg_wdata[2:0]))
        else $error("stillness limit high bits misplaced");
    // Upper byte of the stillness hold comes from its own register
    a_hold_join: assert property (
        ce && bus_ok && reg_wr && reg_addr == OFS_SHOLD_HIGH |=>
            cur_ff.shold[15:8] == $past(reg_wdata))
        else $error("stillness hold high byte misplaced");
    // Hold of zero or one: a single still sample is enough
    a_still_single: assert property (
        ce && sample_valid && still_on && still_qual && cur_ff.shold <= 16'h0001
            && !restart_hit |=> stillness_flag)
        else $error("single sample did not raise stillness");
    // A broken run can never be the one that raises stillness
    a_still_gap: assert property (
        ce && sample_valid && still_on && !still_qual && !restart_hit |=>
            !$rose(stillness_flag))
        else $error("stillness raised by a failing sample");
    // With motion detection on, its counter only moves on a sample; idle clocks leave it alone
    a_count_step: assert property (
        ce && act_on && !sample_valid && !restart_hit |=> $stable(cur_ff.mcnt))
        else $error("motion counter moved without a sample");
    // Every motion event leaves the motion flag set
    a_motion_set: assert property (
        ce && act_event && !restart_hit |=> motion_flag)
        else $error("motion event lost");
    // Every stillness event leaves the stillness flag set
    a_still_set: assert property (
        ce && still_event && !restart_hit |=> stillness_flag)
        else $error("stillness event lost");
endmodule // mtr_regs

// file: pkg/mtr_pkg.sv
package mtr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS      = 8'h0B;
    localparam logic [7:0] OFS_TEMP_LOW    = 8'h14;
    localparam logic [7:0] OFS_TEMP_HIGH   = 8'h15;
    localparam logic [7:0] OFS_RESTART     = 8'h1F;
    localparam logic [7:0] OFS_MLIM_LOW    = 8'h20;
    localparam logic [7:0] OFS_MLIM_HIGH   = 8'h21;
    localparam logic [7:0] OFS_MHOLD       = 8'h22;
    localparam logic [7:0] OFS_SLIM_LOW    = 8'h23;
    localparam logic [7:0] OFS_SLIM_HIGH   = 8'h24;
    localparam logic [7:0] OFS_SHOLD_LOW   = 8'h25;
    localparam logic [7:0] OFS_SHOLD_HIGH  = 8'h26;
    localparam logic [7:0] OFS_DETECT_CTL  = 8'h27;
    // Key byte that triggers a software restart
    localparam logic [7:0] RESTART_KEY     = 8'h52;
    // Reset values
    localparam logic [7:0] RST_BYTE        = 8'h00;
    // Field positions and widths
    localparam int         BIT_MOTION_ON   = 0;
    localparam int         BIT_STILL_ON    = 2;
    localparam int         BIT_MOTION_FLAG = 4;
    localparam int         BIT_STILL_FLAG  = 5;
    localparam int         LIM_HIGH_W      = 3;
    localparam int         SAMPLE_W        = 12;
    // Quiet time after a restart: 0.5 ms at 250 MHz, rounded down
    localparam int         RESTART_WAIT_NS = 500000;
    localparam int         CLK_PERIOD_NS   = 4;
    localparam int         RESTART_CYCLES  = RESTART_WAIT_NS / CLK_PERIOD_NS;
    localparam int         WAIT_W          = 17;

    // Restart sequencing
    typedef enum logic {
        MTR_RUN,
        MTR_RESTART_WAIT
    } mtr_mode_e;

    // All state of the block
    typedef struct packed {
        mtr_mode_e          mode;
        logic [WAIT_W-1:0]  wait_cnt;
        logic [7:0]         mlim_low;
        logic [2:0]         mlim_high;
        logic [7:0]         mhold;
        logic [7:0]         slim_low;
        logic [2:0]         slim_high;
        logic [15:0]        shold;
        logic [7:0]         detect_ctl;
        logic [11:0]        temp;
        logic [7:0]         mcnt;
        logic [15:0]        scnt;
        logic               motion_flag;
        logic               still_flag;
        logic [7:0]         rdata;
        logic               rvalid;
        logic               int_oe_n;
        logic               standby;
    } mtr_state_s;
endpackage
